// ==== design/dca_ca_input.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: ACTIVATE takes the address as row, READ/WRITE takes it as column.
// RULE_02: MODE REGISTER SET loads the address opcode into the chosen mode register.
// RULE_03: Address bit 17 counts only for x4 organisation, else forced low.
// RULE_04: READ/WRITE with A10 high auto-precharge the bank, low leaves it open.
// RULE_05: PRECHARGE with A10 low closes one bank, high closes all.
// RULE_06: Single-bank precharge targets bank group and bank given with the command.
// RULE_07: READ/WRITE with A12 high run full burst, low chops the burst.
// RULE_08: ACT_n low with chip select gives ACTIVATE; RAS/CAS/WE become A16/A15/A14.
// RULE_09: Bank address picks bank in group, and with group picks mode register.
// RULE_10: Bank group picks the group for REFRESH, ACTIVATE, READ, WRITE, PRECHARGE.
// RULE_11: Two bank-group bits for x4/x8; x16 uses only the lowest bit.
// RULE_12: Stacked 2H/4H/8H dies compare chip ID as part of the command.
// RULE_13: All command, address and control inputs sampled on the rising clock.
// RULE_14: CKE high enables internal clocks, buffers, drivers; low disables them.
// RULE_15: CKE low enters precharge power-down or self refresh when idle, else active.
// RULE_16: Self refresh exit follows CKE without waiting for a clock edge.
// RULE_17: Controller holds CKE high throughout read and write accesses.
// RULE_18: Power-down keeps only clock, ODT, reset and CKE buffers on.
// RULE_19: Self refresh keeps only CKE and reset buffers on.
// RULE_20: Chip select high at the sampling edge masks every command.
// RULE_21: Chip select picks the rank and is part of the command code.
// RULE_22: ACT_n high makes RAS/CAS/WE command pins for non-activate commands.
// RULE_23: ODT applies termination when registered high, ignored if termination disabled.
// RULE_24: Reset low clears the device asynchronously; controller keeps it high normally.
// RULE_25: With parity enabled, a parity mismatch over command and address is caught.
// RULE_26: Controller presents the whole command word aligned at one clock edge.
module dca_ca_input
	import dca_pkg::*;
(
	input  wire logic                      i_clk,
	input  wire logic                      i_nrst,
	input  wire dca_pkg::dca_ca_s          i_ca,
	input  wire logic                      i_cke,
	input  wire logic                      i_odt,
	input  wire dca_pkg::dca_org_e         i_org,
	input  wire dca_pkg::dca_stack_e       i_stack,
	input  wire logic [dca_pkg::CID_W-1:0] i_die_id,
	input  wire logic [dca_pkg::MR_IDX_W-1:0] i_mr_rd_idx,
	output dca_pkg::dca_cmd_s              o_cmd,
	output logic [dca_pkg::MR_W-1:0]       o_mr_data,
	output logic                           o_par_err,
	output logic                           o_odt_on,
	output dca_pkg::dca_pwr_e              o_pwr_state,
	output logic [dca_pkg::NUM_BANKS-1:0]  o_banks_open,
	output logic                           o_int_clk_en,
	output logic                           o_ca_buf_en,
	output logic                           o_clk_buf_en,
	output logic                           o_odt_buf_en,
	output logic                           o_out_drv_en
);
	import dca_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		dca_pwr_e             pwr;
		logic                 cke_q;
		logic [NUM_BANKS-1:0] banks;
		logic                 par_en;
		logic                 rtt_en;
		logic                 par_err;
		logic                 odt_on;
		dca_cmd_s             cmd;
	} dca_st_s;

	dca_st_s st_reg;
	dca_st_s st_next;

	logic [BG_W-1:0]   bg_eff;
	logic              a17_eff;
	logic [CID_W-1:0]  cid_mask;
	logic              cid_ok;
	logic              par_calc;
	logic              sel;
	logic              par_bad;
	logic              take;
	dca_cmd_e          dec;
	logic [ROW_W-1:0]  row;
	logic [BANK_W-1:0] bank;
	logic              cke_fall;

	// ---------------------------------------------------------------
	// Address qualification
	// ---------------------------------------------------------------
	// Organisation masks unused address and group bits
	assign bg_eff  = (i_org == ORG_X16) ? {1'b0, i_ca.bg[0]} : i_ca.bg;  // [RULE_11]
	assign a17_eff = (i_org == ORG_X4) ? i_ca.a17 : 1'b0;                // [RULE_03]
	assign row     = {a17_eff, i_ca.ras_n, i_ca.cas_n, i_ca.we_n, i_ca.addr};  // [RULE_08]
	assign bank    = {bg_eff, i_ca.ba};  // [RULE_10]

	// Chip ID bits compared depend on stack height
	always_comb begin
		unique case (i_stack)
			STK_1H: cid_mask = 3'h0;
			STK_2H: cid_mask = 3'h1;
			STK_4H: cid_mask = 3'h3;
			STK_8H: cid_mask = 3'h7;
		endcase
	end
	assign cid_ok = ((i_ca.cid ^ i_die_id) & cid_mask) == 3'h0;  // [RULE_12]

	// Even parity over the command and address word
	assign par_calc = ^{i_ca.act_n, i_ca.ras_n, i_ca.cas_n, i_ca.we_n, bg_eff, i_ca.ba,
		a17_eff, i_ca.addr};

	// Command acceptance: buffers live, CKE high last edge, selected
	assign sel      = (st_reg.pwr == PS_ACTIVE) && st_reg.cke_q
		&& !i_ca.cs_n && cid_ok;  // [RULE_20] [RULE_21]
	assign par_bad  = sel && st_reg.par_en && (par_calc != i_ca.par);  // [RULE_25]
	assign take     = sel && !par_bad;
	assign cke_fall = st_reg.cke_q && !i_cke;

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	always_comb begin
		dec = CMD_NOP;
		if (!i_ca.act_n) begin
			dec = CMD_ACT;  // [RULE_08]
		end else begin
			unique case ({i_ca.ras_n, i_ca.cas_n, i_ca.we_n})  // [RULE_22]
				3'b000: dec = CMD_MRS;
				3'b001: dec = CMD_REF;
				3'b010: dec = i_ca.addr[AP_BIT] ? CMD_PREA : CMD_PRE;  // [RULE_05]
				3'b101: dec = CMD_RD;
				3'b100: dec = CMD_WR;
				default: dec = CMD_NOP;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_next           = st_reg;
		st_next.cke_q     = i_cke;
		st_next.cmd.valid = 1'b0;
		st_next.par_err   = par_bad;
		// Termination only while ODT buffer lives and termination is enabled
		st_next.odt_on    = i_odt && st_reg.rtt_en && (st_reg.pwr != PS_SELF_REF);  // [RULE_23]
		unique case (st_reg.pwr)
			PS_ACTIVE: begin
				if (take && !(cke_fall && dec == CMD_REF) && dec != CMD_NOP) begin  // [RULE_13]
					st_next.cmd.valid      = 1'b1;
					st_next.cmd.cmd        = dec;
					st_next.cmd.bg         = bg_eff;  // [RULE_10]
					st_next.cmd.ba         = i_ca.ba;  // [RULE_09]
					st_next.cmd.row        = row;  // [RULE_01]
					st_next.cmd.col        = i_ca.addr[COL_W-1:0];  // [RULE_01]
					st_next.cmd.auto_pre   = i_ca.addr[AP_BIT];  // [RULE_04]
					st_next.cmd.burst_chop = !i_ca.addr[BC_BIT];  // [RULE_07]
					st_next.cmd.mr_idx     = {bg_eff[0], i_ca.ba};  // [RULE_09]
					st_next.cmd.opcode     = row;  // [RULE_02]
				end
				if (take) begin
					unique case (dec)
						CMD_ACT: st_next.banks[bank] = 1'b1;
						CMD_PRE: st_next.banks[bank] = 1'b0;  // [RULE_06]
						CMD_PREA: st_next.banks = BANKS_RST;  // [RULE_05]
						CMD_RD, CMD_WR: begin
							if (i_ca.addr[AP_BIT]) begin
								st_next.banks[bank] = 1'b0;  // [RULE_04]
							end
						end
						CMD_MRS: begin
							if ({bg_eff[0], i_ca.ba} == MR_IDX_PAR) begin
								st_next.par_en = |i_ca.addr[PAR_MSB:PAR_LSB];  // [RULE_25]
							end
							if ({bg_eff[0], i_ca.ba} == MR_IDX_RTT) begin
								st_next.rtt_en = |i_ca.addr[RTT_MSB:RTT_LSB];  // [RULE_23]
							end
						end
						default: begin
						end
					endcase
				end
				// CKE falling picks the low-power state
				if (cke_fall) begin
					if (take && dec == CMD_REF && st_reg.banks == BANKS_RST) begin
						st_next.pwr = PS_SELF_REF;  // [RULE_15]
					end else if (st_reg.banks == BANKS_RST) begin
						st_next.pwr = PS_PRE_PD;  // [RULE_15]
					end else begin
						st_next.pwr = PS_ACT_PD;  // [RULE_15]
					end
				end
			end
			PS_PRE_PD, PS_ACT_PD, PS_SELF_REF: begin
				if (i_cke) begin
					st_next.pwr = PS_ACTIVE;
				end
			end
		endcase
	end

	// State register, cleared whenever reset is low
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg <= '0;  // [RULE_24]
		end else begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------------------------
	// Mode register storage
	// ---------------------------------------------------------------
	dca_mr_mem #(
		.DEPTH (MR_DEPTH),
		.WIDTH (MR_W)
	) u_mr_mem (
		.i_clk     (i_clk),
		.i_nrst    (i_nrst),
		.i_wr_en   (take && dec == CMD_MRS && st_reg.pwr == PS_ACTIVE),  // [RULE_02]
		.i_wr_idx  ({bg_eff[0], i_ca.ba}),
		.i_wr_data (row),
		.i_rd_idx  (i_mr_rd_idx),
		.o_rd_data (o_mr_data)
	);

	// ---------------------------------------------------------------
	// Outputs and buffer gating
	// ---------------------------------------------------------------
	assign o_cmd        = st_reg.cmd;
	assign o_par_err    = st_reg.par_err;
	assign o_odt_on     = st_reg.odt_on;
	assign o_pwr_state  = st_reg.pwr;
	assign o_banks_open = st_reg.banks;
	// CKE gates the internal clock straight from the pin, no edge needed
	assign o_int_clk_en = i_cke;  // [RULE_14] [RULE_16]
	assign o_ca_buf_en  = (st_reg.pwr == PS_ACTIVE);  // [RULE_18] [RULE_19]
	assign o_clk_buf_en = (st_reg.pwr != PS_SELF_REF) || i_cke;  // [RULE_19] [RULE_16]
	assign o_odt_buf_en = (st_reg.pwr != PS_SELF_REF) || i_cke;  // [RULE_18]
	// Drivers stay on only in active state with CKE high
	assign o_out_drv_en = (st_reg.pwr == PS_ACTIVE) && i_cke;  // [RULE_14] [RULE_17]

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	sequence s_cke_fall_ref;
		st_reg.pwr == PS_ACTIVE && st_reg.cke_q && !i_cke && take && dec == CMD_REF
			&& st_reg.banks == BANKS_RST;
	endsequence

	sequence s_in_self_ref;
		st_reg.pwr == PS_SELF_REF;
	endsequence

	a_cs_high_mask: assert property (i_ca.cs_n |=> !o_cmd.valid)  // [RULE_20]
		else $error("command accepted with chip select high");
	a_act_row_bits: assert property (take && dec == CMD_ACT && !cke_fall |=>  // [RULE_08]
		o_cmd.valid && o_cmd.cmd == CMD_ACT
		&& o_cmd.row[16:14] == $past({i_ca.ras_n, i_ca.cas_n, i_ca.we_n}))
		else $error("activate row bits do not follow command pins");
	a_rd_auto_pre: assert property (take && dec == CMD_RD  // [RULE_04]
		&& i_ca.addr[AP_BIT] && !cke_fall |=> o_cmd.auto_pre && !st_reg.banks[$past(bank)])
		else $error("read with auto precharge left bank open");
	a_burst_chop: assert property (take && (dec == CMD_RD || dec == CMD_WR)  // [RULE_07]
		&& !cke_fall |=> o_cmd.burst_chop == !$past(i_ca.addr[BC_BIT]))
		else $error("burst chop does not follow A12");
	a_prea_closes: assert property (take && dec == CMD_PREA  // [RULE_05]
		|=> st_reg.banks == BANKS_RST)
		else $error("precharge all left a bank open");
	a_pre_single: assert property (take && dec == CMD_PRE  // [RULE_06]
		|=> !st_reg.banks[$past(bank)])
		else $error("single bank precharge left target bank open");
	a_x16_group: assert property (i_org == ORG_X16 && take && dec != CMD_NOP  // [RULE_11]
		&& !cke_fall |=> o_cmd.bg[1] == 1'b0)
		else $error("x16 part used upper bank group bit");
	a_a17_mask: assert property (i_org != ORG_X4 && take && dec != CMD_NOP  // [RULE_03]
		&& !cke_fall |=> o_cmd.row[17] == 1'b0)
		else $error("A17 used outside x4 organisation");
	a_mrs_load: assert property (take && dec == CMD_MRS  // [RULE_02]
		&& i_mr_rd_idx == {bg_eff[0], i_ca.ba}
		&& $stable(i_mr_rd_idx) [*1] ##1 $stable(i_mr_rd_idx)
		|=> o_mr_data == $past(row, 2))
		else $error("mode register did not load opcode");
	a_sr_entry: assert property (s_cke_fall_ref |=> s_in_self_ref ##0 !o_ca_buf_en)  // [RULE_15]
		else $error("self refresh not entered on CKE fall with refresh");
	a_sr_buffers: assert property (s_in_self_ref ##0 !i_cke  // [RULE_19]
		|-> !o_clk_buf_en && !o_odt_buf_en && !o_ca_buf_en && !o_int_clk_en)
		else $error("buffer left on during self refresh");
	a_sr_wake: assert property (s_in_self_ref ##0 i_cke  // [RULE_16]
		|=> o_pwr_state == PS_ACTIVE)
		else $error("self refresh not left after CKE rose");
	a_pd_buffers: assert property (st_reg.pwr == PS_PRE_PD  // [RULE_18]
		|| st_reg.pwr == PS_ACT_PD |-> !o_ca_buf_en && o_clk_buf_en && o_odt_buf_en)
		else $error("wrong buffer set during power down");
	a_pd_drop: assert property (st_reg.pwr != PS_ACTIVE |=> !o_cmd.valid)  // [RULE_14]
		else $error("command accepted while input buffers are off");
	a_odt_gate: assert property (!st_reg.rtt_en |=> !o_odt_on)  // [RULE_23]
		else $error("termination applied while disabled");
	a_par_reject: assert property (par_bad |=> o_par_err && !o_cmd.valid)  // [RULE_25]
		else $error("parity error not flagged or command not dropped");

endmodule

// ==== design/dca_pkg.sv ====
package dca_pkg;

	// ---------------------------------------------------------------
	// Widths and field positions
	// ---------------------------------------------------------------
	localparam int ADDR_LO_W   = 14;  // A0..A13 on dedicated pins
	localparam int ROW_W       = 18;  // A0..A17
	localparam int COL_W       = 10;  // A0..A9
	localparam int BG_W        = 2;
	localparam int BA_W        = 2;
	localparam int BANK_W      = BG_W + BA_W;
	localparam int NUM_BANKS   = 16;
	localparam int CID_W       = 3;
	localparam int MR_IDX_W    = 3;
	localparam int MR_DEPTH    = 8;
	localparam int MR_W        = 18;
	localparam int AP_BIT      = 10;  // Auto precharge / all banks
	localparam int BC_BIT      = 12;  // Burst chop, low active

	// ---------------------------------------------------------------
	// Mode register fields steering this block
	// ---------------------------------------------------------------
	localparam logic [MR_IDX_W-1:0] MR_IDX_RTT = 3'h1;
	localparam logic [MR_IDX_W-1:0] MR_IDX_PAR = 3'h5;
	localparam int RTT_LSB     = 8;
	localparam int RTT_MSB     = 10;
	localparam int PAR_LSB     = 0;
	localparam int PAR_MSB     = 2;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [NUM_BANKS-1:0] BANKS_RST  = 16'h0000;
	localparam logic                 PAR_EN_RST = 1'h0;
	localparam logic                 RTT_EN_RST = 1'h0;
	localparam logic [MR_W-1:0]      MR_RST     = 18'h00000;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {ORG_X4, ORG_X8, ORG_X16} dca_org_e;
	typedef enum logic [1:0] {STK_1H, STK_2H, STK_4H, STK_8H} dca_stack_e;
	typedef enum logic [2:0] {
		CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA, CMD_REF, CMD_MRS
	} dca_cmd_e;
	typedef enum logic [1:0] {PS_ACTIVE, PS_PRE_PD, PS_ACT_PD, PS_SELF_REF} dca_pwr_e;

	// Command/address word as seen at one clock crossing
	typedef struct packed {
		logic                 cs_n;
		logic                 act_n;
		logic                 ras_n;   // Also A16
		logic                 cas_n;   // Also A15
		logic                 we_n;    // Also A14
		logic [BG_W-1:0]      bg;
		logic [BA_W-1:0]      ba;
		logic                 a17;
		logic [ADDR_LO_W-1:0] addr;
		logic [CID_W-1:0]     cid;
		logic                 par;
	} dca_ca_s;

	// Decoded command handed to the array logic
	typedef struct packed {
		logic                valid;
		dca_cmd_e            cmd;
		logic [BG_W-1:0]     bg;
		logic [BA_W-1:0]     ba;
		logic [ROW_W-1:0]    row;
		logic [COL_W-1:0]    col;
		logic                auto_pre;
		logic                burst_chop;
		logic [MR_IDX_W-1:0] mr_idx;
		logic [MR_W-1:0]     opcode;
	} dca_cmd_s;

endpackage

// ==== design/dca_mr_mem.sv ====
`timescale 1ns/1ps

// Mode register storage, one write port and one registered read port
module dca_mr_mem
	import dca_pkg::*;
#(
	parameter int DEPTH = dca_pkg::MR_DEPTH,
	parameter int WIDTH = dca_pkg::MR_W
) (
	input  wire logic                     i_clk,
	input  wire logic                     i_nrst,
	input  wire logic                     i_wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] i_wr_idx,
	input  wire logic [WIDTH-1:0]         i_wr_data,
	input  wire logic [$clog2(DEPTH)-1:0] i_rd_idx,
	output logic      [WIDTH-1:0]         o_rd_data
);
	import dca_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0]            rd;
	} dca_mem_s;

	dca_mem_s st_reg;
	dca_mem_s st_next;

	// Next state: write one entry, register the read word
	always_comb begin
		st_next = st_reg;
		if (i_wr_en) begin
			st_next.mem[i_wr_idx] = i_wr_data;
		end
		st_next.rd = st_reg.mem[i_rd_idx];
	end

	// State register
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rd_data = st_reg.rd;

endmodule

// ==== verif/dca_host_model.sv ====
`timescale 1ns/1ps

// Host controller model: drives the command word and clock enable
module dca_host_model (
	input  wire logic        i_clk,
	output dca_pkg::dca_ca_s o_ca,
	output logic             o_cke
);
	import dca_pkg::*;

	// ---------------------------------------------------------------
	// Idle lines until the first command
	// ---------------------------------------------------------------
	initial begin
		o_ca  = '1;    // Deselected
		o_cke = 1'h0;
	end

	// ---------------------------------------------------------------
	// One command: whole word for one crossing, then deselect
	// ---------------------------------------------------------------
	task automatic send(input dca_ca_s w, input logic cke, input logic bad);
		dca_ca_s d;
		d     = w;
		d.par = ^{w.act_n, w.ras_n, w.cas_n, w.we_n, w.bg, w.ba, w.a17, w.addr} ^ bad;
		@(negedge i_clk);
		o_ca  <= d;    // Aligned word at one crossing
		o_cke <= cke;  // Held high through accesses
		@(negedge i_clk);
		o_ca  <= dca_ca_s'({1'h1, ~d[$bits(dca_ca_s)-2:0]}); // Deselect, lines flipped
	endtask

	// Clock enable alone, for the wake-up that needs no clock edge
	task automatic set_cke(input logic cke);
		@(negedge i_clk);
		o_cke <= cke;
	endtask
endmodule

// ==== verif/dca_ca_input_tb.sv ====
`timescale 1ns/1ps

module dca_ca_input_tb;
	import dca_pkg::*;

	typedef struct packed {
		logic       cs_n;
		logic [3:0] cmd;   // {act_n, ras_n, cas_n, we_n}
		logic [1:0] bg;
		logic [1:0] ba;
		logic       a17;
		logic [13:0] addr;
		dca_cmd_e   exp;
	} dca_row_s;

	localparam dca_row_s IDLE = '{1'h1, 4'hF, 2'h0, 2'h0, 1'h0, 14'h0000, CMD_NOP};
	localparam dca_row_s ACT2 = '{1'h0, 4'h0, 2'h0, 2'h2, 1'h0, 14'h0000, CMD_ACT};
	localparam dca_row_s REF0 = '{1'h0, 4'h9, 2'h0, 2'h0, 1'h0, 14'h0000, CMD_REF};
	localparam dca_row_s PREA = '{1'h0, 4'hA, 2'h0, 2'h0, 1'h0, 14'h0400, CMD_PREA};
	localparam dca_row_s rows [11] = '{
		'{1'h0, 4'h5, 2'h2, 2'h1, 1'h1, 14'h2ABC, CMD_ACT},
		'{1'h0, 4'h2, 2'h1, 2'h3, 1'h0, 14'h3FFF, CMD_ACT},
		'{1'h0, 4'hD, 2'h2, 2'h1, 1'h0, 14'h1123, CMD_RD},
		'{1'h0, 4'hC, 2'h2, 2'h1, 1'h0, 14'h0455, CMD_WR},
		'{1'h0, 4'hA, 2'h1, 2'h3, 1'h0, 14'h0000, CMD_PRE},
		'{1'h0, 4'h0, 2'h3, 2'h0, 1'h0, 14'h0001, CMD_ACT},
		'{1'h1, 4'hD, 2'h3, 2'h0, 1'h0, 14'h0000, CMD_NOP},
		PREA,
		'{1'h0, 4'hE, 2'h0, 2'h0, 1'h0, 14'h0000, CMD_NOP},
		'{1'h0, 4'h9, 2'h1, 2'h0, 1'h0, 14'h0000, CMD_REF},
		'{1'h0, 4'h8, 2'h0, 2'h3, 1'h0, 14'h2A5A, CMD_MRS}};

	logic              i_clk, i_nrst, i_odt;
	dca_org_e          i_org;
	dca_stack_e        i_stack;
	logic [2:0]        i_die_id, i_mr_rd_idx;
	dca_ca_s           ca, w;
	logic              cke, int_clk_en, ca_buf_en, clk_buf_en, odt_buf_en, out_drv_en;
	dca_cmd_s          o_cmd;
	logic [MR_W-1:0]   mr_data;
	logic              par_err, odt_on;
	dca_pwr_e          pwr;
	logic [15:0]       banks_open, banks;
	logic [4:0]        en;
	logic [3:0]        idx;
	dca_row_s          r;
	int                failures, checks, cyc;

	dca_host_model i_host (.i_clk(i_clk), .o_ca(ca), .o_cke(cke));

	dca_ca_input i_dut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_ca(ca), .i_cke(cke), .i_odt(i_odt),
		.i_org(i_org), .i_stack(i_stack), .i_die_id(i_die_id), .i_mr_rd_idx(i_mr_rd_idx),
		.o_cmd(o_cmd), .o_mr_data(mr_data), .o_par_err(par_err), .o_odt_on(odt_on),
		.o_pwr_state(pwr), .o_banks_open(banks_open), .o_int_clk_en(int_clk_en),
		.o_ca_buf_en(ca_buf_en), .o_clk_buf_en(clk_buf_en), .o_odt_buf_en(odt_buf_en),
		.o_out_drv_en(out_drv_en));

	// Enables gathered for compact buffer checks
	assign en = {int_clk_en, ca_buf_en, clk_buf_en, odt_buf_en, out_drv_en};

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic dca_ca_s mk(input dca_row_s x);
		mk      = '0;
		{mk.cs_n, mk.act_n, mk.ras_n, mk.cas_n, mk.we_n} = {x.cs_n, x.cmd};
		mk.bg   = x.bg;
		mk.ba   = x.ba;
		mk.a17  = x.a17;
		mk.addr = x.addr;
	endfunction

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Clock and hang guard
	initial begin
		i_clk = 1'h0;
		forever #2.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 4000) begin
			failures++;
			results();
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{i_nrst, i_odt, i_die_id, i_mr_rd_idx} = {1'h0, 1'h1, 3'h0, 3'h3};
		{banks, failures, checks, cyc} = {16'h0000, 96'h0};
		i_org   = ORG_X4;
		i_stack = STK_1H;
		repeat (20) @(negedge i_clk);
		chk("rst_valid", o_cmd.valid, 1'h0);
		chk("rst_pwr", pwr, PS_ACTIVE);
		chk("rst_mr", mr_data, MR_RST);
		i_nrst = 1'h1;
		i_host.send(mk(IDLE), 1'h1, 1'h0);
		chk("odt_off", odt_on, 1'h0);
		// Table of ordinary commands
		for (int i = 0; i < 11; i++) begin
			r   = rows[i];
			idx = {r.bg, r.ba};
			i_host.send(mk(r), 1'h1, 1'h0);
			chk("valid", o_cmd.valid, r.exp != CMD_NOP);
			if (r.exp != CMD_NOP) chk("cmd", o_cmd.cmd, r.exp);
			if (r.exp inside {CMD_ACT, CMD_RD, CMD_WR, CMD_PRE})
				chk("bank", {o_cmd.bg, o_cmd.ba}, idx);
			if (r.exp == CMD_REF) chk("ref_bg", o_cmd.bg, r.bg);
			if (r.exp == CMD_ACT) chk("row", o_cmd.row, {r.a17, r.cmd[2:0], r.addr});
			if (r.exp inside {CMD_RD, CMD_WR}) begin
				chk("col", o_cmd.col, r.addr[9:0]);
				chk("ap", o_cmd.auto_pre, r.addr[10]);
				chk("chop", o_cmd.burst_chop, !r.addr[12]);
			end
			if (r.exp == CMD_MRS) begin
				chk("mr_idx", o_cmd.mr_idx, {r.bg[0], r.ba});
				chk("opcode", o_cmd.opcode, {r.a17, r.cmd[2:0], r.addr});
			end
			case (r.exp)
				CMD_ACT: banks[idx] = 1'h1;
				CMD_PRE: banks[idx] = 1'h0;
				CMD_PREA: banks = '0;
				CMD_RD, CMD_WR: if (r.addr[10]) banks[idx] = 1'h0;
				default: ;
			endcase
			chk("banks", banks_open, banks);
		end
		repeat (2) @(negedge i_clk);
		chk("mr_data", mr_data, 18'h02A5A);
		// Termination on once enabled in mode register 1
		i_host.send(mk('{1'h0, 4'h8, 2'h0, 2'h1, 1'h0, 14'h0100, CMD_MRS}), 1'h1, 1'h0);
		@(negedge i_clk);
		chk("odt_on", odt_on, 1'h1);
		// Parity enabled in mode register 5, then a corrupted word
		i_host.send(mk('{1'h0, 4'h8, 2'h1, 2'h1, 1'h0, 14'h0001, CMD_MRS}), 1'h1, 1'h0);
		i_host.send(mk(ACT2), 1'h1, 1'h1);
		chk("par_valid", o_cmd.valid, 1'h0);
		chk("par_err", par_err, 1'h1);
		i_host.send(mk(PREA), 1'h1, 1'h0);
		chk("par_ok", o_cmd.valid, 1'h1);
		i_host.send(mk('{1'h0, 4'h8, 2'h1, 2'h1, 1'h0, 14'h0000, CMD_MRS}), 1'h1, 1'h0);
		// Stacked die: only a matching chip ID is taken
		i_stack  = STK_2H;
		i_die_id = 3'h2;
		w = mk(ACT2);
		w.cid = 3'h1;
		i_host.send(w, 1'h1, 1'h0);
		chk("cid_bad", o_cmd.valid, 1'h0);
		w.cid = 3'h2;
		i_host.send(w, 1'h1, 1'h0);
		chk("cid_ok", o_cmd.valid, 1'h1);
		// Taller stacks compare more chip ID bits
		i_stack  = STK_4H;
		i_die_id = 3'h5;
		w.cid    = 3'h1;
		i_host.send(w, 1'h1, 1'h0);
		chk("cid_4h", o_cmd.valid, 1'h1);
		i_stack = STK_8H;
		i_host.send(w, 1'h1, 1'h0);
		chk("cid_8h", o_cmd.valid, 1'h0);
		i_stack = STK_1H;
		// x16: upper bank-group bit and A17 dropped
		i_org = ORG_X16;
		i_host.send(mk('{1'h0, 4'h0, 2'h3, 2'h1, 1'h1, 14'h0000, CMD_ACT}), 1'h1, 1'h0);
		chk("x16_bg", o_cmd.bg, 2'h1);
		chk("x16_a17", o_cmd.row[17], 1'h0);
		// x8: both bank-group bits kept, A17 still dropped
		i_org = ORG_X8;
		i_host.send(mk('{1'h0, 4'h0, 2'h3, 2'h1, 1'h1, 14'h0000, CMD_ACT}), 1'h1, 1'h0);
		chk("x8_bg", o_cmd.bg, 2'h3);
		chk("x8_a17", o_cmd.row[17], 1'h0);
		i_org = ORG_X4;
		// Active power-down with rows open
		i_host.send(mk(IDLE), 1'h0, 1'h0);
		chk("act_pd", pwr, PS_ACT_PD);
		chk("pd_bufs", en, 5'h06);
		i_host.send(mk(ACT2), 1'h0, 1'h0);
		chk("pd_drop", o_cmd.valid, 1'h0);
		i_host.send(mk(IDLE), 1'h1, 1'h0);
		chk("pd_exit", pwr, PS_ACTIVE);
		// Precharge power-down with all banks idle
		i_host.send(mk(PREA), 1'h1, 1'h0);
		i_host.send(mk(IDLE), 1'h0, 1'h0);
		chk("pre_pd", pwr, PS_PRE_PD);
		i_host.send(mk(IDLE), 1'h1, 1'h0);
		// Self refresh entry, then asynchronous exit
		i_host.send(mk(REF0), 1'h0, 1'h0);
		chk("sr_valid", o_cmd.valid, 1'h0);
		chk("sr_pwr", pwr, PS_SELF_REF);
		chk("sr_bufs", en, 5'h00);
		i_host.set_cke(1'h1);
		#1;
		chk("sr_async", {int_clk_en, clk_buf_en, odt_buf_en}, 3'h7);
		@(negedge i_clk);
		chk("sr_exit", pwr, PS_ACTIVE);
		// Reset in mid-run clears open banks at once
		i_host.send(mk(ACT2), 1'h1, 1'h0);
		i_nrst = 1'h0;
		#1;
		chk("mid_rst", banks_open, BANKS_RST);
		@(negedge i_clk);
		i_nrst = 1'h1;
		i_host.send(mk(ACT2), 1'h1, 1'h0);
		chk("rst_first", o_cmd.valid, 1'h1);
		i_host.send(mk(ACT2), 1'h1, 1'h0);
		chk("post_rst", o_cmd.valid, 1'h1);
		results();
	end
endmodule
